// file: rtl/rtcb_consts.svh
// How it works
// [RULE1] ten 16-bit backup words, 20 bytes, kept across main-domain resets
// [RULE2] counters run always (the code stops them when the source is RTCB_SRC_OFF); tick and alarm each raise an interrupt flag
// [RULE3] counter clock chosen from low-speed crystal, internal oscillator, or fast clock/128
// [RULE4] optional 512 Hz calibration output, counter clock divided by 64
// [RULE5] 32-bit loadable counter advances per tick; alarm when a tick brings it to the compare value (a load does not)
// [RULE6] 20-bit prescaler resets to one tick per second at 32.768 kHz
// [RULE7] counter, prescaler and clock source keep running in stop or standby
// [RULE8] alarm serves as a wake-up source out of stop and standby
// [RULE9] prescaler counts down from reload, ticks on wrap, ratio reload plus one
`ifndef RTCB_CONSTS_SVH
`define RTCB_CONSTS_SVH

`define RTCB_OFF_CTRL   12'h000
`define RTCB_OFF_STAT   12'h004
`define RTCB_OFF_MASK   12'h008
`define RTCB_OFF_RELOAD 12'h00C
`define RTCB_OFF_PVAL   12'h010
`define RTCB_OFF_CNT    12'h014
`define RTCB_OFF_ALARM  12'h018
`define RTCB_OFF_BKP0   12'h040
`define RTCB_BKP_WORDS  10

`define RTCB_CTRL_SRC_LO 0
`define RTCB_CTRL_SRC_HI 1
`define RTCB_CTRL_CALEN  2
`define RTCB_CTRL_WKEN   3
`define RTCB_CTRL_RST    4'h0

`define RTCB_ST_TICK  0
`define RTCB_ST_ALARM 1
`define RTCB_ST_W     2

`define RTCB_RELOAD_RST 20'h07FFF
`define RTCB_FAST_LAST  7'h7F
`define RTCB_CAL_LAST   5'h1F

`endif

// file: rtl/rtcb_pkg.sv
`default_nettype none
package rtcb_pkg;
   typedef enum logic [1:0] {
      RTCB_SRC_LSE = 2'h0,
      RTCB_SRC_LSI = 2'h1,
      RTCB_SRC_FAST = 2'h2,
      RTCB_SRC_OFF = 2'h3
   } rtcb_src_t;
   typedef logic [19:0] rtcb_presc_t;
endpackage
`default_nettype wire

// file: rtl/rtcb_prescaler.sv
`include "rtcb_consts.svh"
`default_nettype none
module rtcb_prescaler (
   // clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // control
   input  wire logic                 step,
   input  wire logic                 restart,
   input  wire rtcb_pkg::rtcb_presc_t reload,
   // status
   output logic                      tick_q,
   output rtcb_pkg::rtcb_presc_t     value_q
);
   import rtcb_pkg::*;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value_q <= `RTCB_RELOAD_RST;
         tick_q  <= 1'b0;
      end else if (restart) begin
         value_q <= reload;
         tick_q  <= 1'b0;
      end else if (step) begin
         if (value_q == 20'h00000) begin
            value_q <= reload; // [RULE9]
            tick_q  <= 1'b1;   // [RULE9]
         end else begin
            value_q <= value_q - 20'h00001;
            tick_q  <= 1'b0;
         end
      end else begin
         tick_q <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: rtl/rtcb_top.sv
// Design decisions made here: register access over APB and the address map.
`include "rtcb_consts.svh"
`default_nettype none
module rtcb_top (
   // clock and resets
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        bkp_rstn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // counter clock sources
   input  wire logic        lse_clk,
   input  wire logic        lsi_clk,
   input  wire logic        high_speed_external_clock,
   // system
   input  wire logic        low_power,
   output logic             irq,
   output logic             wakeup,
   output logic             cal_out
);
   import rtcb_pkg::*;

   logic [3:0]             ctrl_q;
   logic [`RTCB_ST_W-1:0]  sts_q;
   logic [`RTCB_ST_W-1:0]  mask_q;
   rtcb_presc_t            reload_q;
   rtcb_presc_t            reload_nx;
   logic                   reload_wr_seen_q;
   logic [31:0]            cnt_q;
   logic [31:0]            alarm_q;
   logic [`RTCB_BKP_WORDS-1:0][15:0] bkp_q;
   logic [2:0]             prev_q;
   logic [6:0]             fast_div_q;
   logic                   src_edge_q;
   logic [4:0]             cal_cnt_q;
   logic                   cal_tog_q;
   logic                   cal_out_q;
   logic                   irq_q;
   logic                   wake_q;
   logic                   ack_q;
   logic [31:0]            rdata_q;
   logic                   err_q;
   logic                   tick;
   rtcb_presc_t            pval;
   rtcb_src_t              src;
   logic [2:0]             rise;
   logic                   setup;
   logic                   wr;
   logic                   w1c_wr;
   logic                   cnt_wr;
   logic                   reload_wr;
   logic [`RTCB_BKP_WORDS-1:0] bkp_wr;
   logic                   hit;
   logic [31:0]            rd_mux;
   logic                   rd_err;
   logic [`RTCB_ST_W-1:0]  sts_set;

   assign src = rtcb_src_t'(ctrl_q[`RTCB_CTRL_SRC_HI:`RTCB_CTRL_SRC_LO]);

   // apb decode; one wait-free access phase after setup
   assign setup     = psel & ~penable;
   assign pready    = ack_q;
   assign prdata    = rdata_q;
   assign pslverr   = err_q;
   assign wr        = psel & penable & ack_q & pwrite & ~err_q;
   assign w1c_wr    = wr & (paddr == `RTCB_OFF_STAT);
   assign cnt_wr    = wr & (paddr == `RTCB_OFF_CNT);
   assign reload_wr = wr & (paddr == `RTCB_OFF_RELOAD);
   // a reload write restarts from the value being written, not the old one
   assign reload_nx = reload_wr ? pwdata[19:0] : reload_q;

   always_comb begin
      rd_mux = 32'h00000000;
      rd_err = 1'b0;
      case (paddr)
         `RTCB_OFF_CTRL:   rd_mux = {28'h0000000, ctrl_q};
         `RTCB_OFF_STAT:   rd_mux = {30'h0000000, sts_q};
         `RTCB_OFF_MASK:   rd_mux = {30'h0000000, mask_q};
         `RTCB_OFF_RELOAD: rd_mux = {12'h000, reload_q};
         `RTCB_OFF_PVAL:   rd_mux = {12'h000, pval};
         `RTCB_OFF_CNT:    rd_mux = cnt_q;
         `RTCB_OFF_ALARM:  rd_mux = alarm_q;
         default: begin
            rd_err = 1'b1;
            for (int i = 0; i < `RTCB_BKP_WORDS; i++) begin
               if (paddr == `RTCB_OFF_BKP0 + 12'(4 * i)) begin
                  rd_mux = {16'h0000, bkp_q[i]};
                  rd_err = 1'b0;
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h00000000;
         err_q   <= 1'b0;
      end else if (setup) begin
         ack_q   <= 1'b1;
         rdata_q <= pwrite ? 32'h00000000 : rd_mux;
         err_q   <= rd_err;
      end else begin
         ack_q <= 1'b0;
      end
   end

   // software-written configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q           <= `RTCB_CTRL_RST;
         mask_q           <= 2'h0;
         reload_q         <= `RTCB_RELOAD_RST; // [RULE6]
         reload_wr_seen_q <= 1'b0;
         alarm_q          <= 32'hFFFFFFFF;
      end else if (wr) begin
         case (paddr)
            `RTCB_OFF_CTRL:   ctrl_q   <= pwdata[3:0];
            `RTCB_OFF_MASK:   mask_q   <= pwdata[`RTCB_ST_W-1:0];
            `RTCB_OFF_ALARM:  alarm_q  <= pwdata;
            `RTCB_OFF_RELOAD: begin
               reload_q         <= pwdata[19:0];
               reload_wr_seen_q <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   // counter clock source selection and edge detection
   assign rise = {high_speed_external_clock, lsi_clk, lse_clk} & ~prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q     <= 3'h0;
         fast_div_q <= 7'h00;
         src_edge_q <= 1'b0;
      end else begin
         prev_q <= {high_speed_external_clock, lsi_clk, lse_clk};
         if (rise[2]) begin
            fast_div_q <= fast_div_q + 7'h01;
         end
         case (src) // [RULE3]
            RTCB_SRC_LSE:  src_edge_q <= rise[0];
            RTCB_SRC_LSI:  src_edge_q <= rise[1];
            RTCB_SRC_FAST: src_edge_q <= rise[2] & (fast_div_q == `RTCB_FAST_LAST);
            default:      src_edge_q <= 1'b0;
         endcase
      end
   end

   // low_power never gates the chain below
   rtcb_prescaler u_presc (
      .pclk    (pclk),
      .presetn (presetn),
      .step    (src_edge_q), // [RULE7]
      .restart (reload_wr),
      .reload  (reload_nx),
      .tick_q  (tick),
      .value_q (pval)
   );

   // 32-bit counter; a software load wins over a tick
   assign hit = tick & ~cnt_wr & ((cnt_q + 32'h00000001) == alarm_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 32'h00000000;
      end else if (cnt_wr) begin
         cnt_q <= pwdata;
      end else if (tick) begin
         cnt_q <= cnt_q + 32'h00000001; // [RULE5]
      end
   end

   // sticky flags, write one to clear, set wins
   assign sts_set = {hit, tick}; // [RULE2]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_q  <= 2'h0;
         irq_q  <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         sts_q  <= (sts_q & ~(w1c_wr ? pwdata[`RTCB_ST_W-1:0] : 2'h0)) | sts_set;
         irq_q  <= |(sts_q & mask_q);
         wake_q <= low_power & ctrl_q[`RTCB_CTRL_WKEN] & sts_q[`RTCB_ST_ALARM]; // [RULE8]
      end
   end

   assign irq    = irq_q;
   assign wakeup = wake_q;

   // calibration output: toggle every 32 counter clock edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_cnt_q <= 5'h00;
         cal_tog_q <= 1'b0;
         cal_out_q <= 1'b0;
      end else begin
         if (src_edge_q) begin
            cal_cnt_q <= cal_cnt_q + 5'h01;
            if (cal_cnt_q == `RTCB_CAL_LAST) begin
               cal_tog_q <= ~cal_tog_q; // [RULE4]
            end
         end
         cal_out_q <= ctrl_q[`RTCB_CTRL_CALEN] & cal_tog_q;
      end
   end

   assign cal_out = cal_out_q;

   // backup words on their own reset
   generate
      for (genvar g = 0; g < `RTCB_BKP_WORDS; g++) begin : g_bkp
         assign bkp_wr[g] = wr & (paddr == `RTCB_OFF_BKP0 + 12'(4 * g));
         always_ff @(posedge pclk or negedge bkp_rstn) begin
            if (!bkp_rstn) begin
               bkp_q[g] <= 16'h0000;
            end else if (bkp_wr[g]) begin
               bkp_q[g] <= pwdata[15:0]; // [RULE1]
            end
         end
      end
   endgenerate

   a_backup_hold: assert property ( // [RULE1]
      @(posedge pclk) disable iff (!bkp_rstn)
      (bkp_wr == 10'h000) |=> $stable(bkp_q)
   ) else $error("backup words changed without a write");

   a_tick_flag: assert property ( // [RULE2]
      @(posedge pclk) disable iff (!presetn)
      tick |=> sts_q[`RTCB_ST_TICK]
   ) else $error("tick did not set its flag");

   a_irq_follow: assert property ( // [RULE2]
      @(posedge pclk) disable iff (!presetn)
      (sts_q[`RTCB_ST_ALARM] && mask_q[`RTCB_ST_ALARM]) |=> irq
   ) else $error("unmasked alarm flag without interrupt");

   a_fast_divide: assert property ( // [RULE3]
      @(posedge pclk) disable iff (!presetn)
      (src == RTCB_SRC_FAST && rise[2] && fast_div_q != `RTCB_FAST_LAST) |=> !src_edge_q
   ) else $error("fast clock edge passed the divider early");

   a_cal_toggle: assert property ( // [RULE4]
      @(posedge pclk) disable iff (!presetn)
      (src_edge_q && cal_cnt_q == `RTCB_CAL_LAST && ctrl_q[`RTCB_CTRL_CALEN] && !wr)
      |=> ##1 (cal_out_q != $past(cal_out_q, 2))
   ) else $error("calibration output missed its toggle");

   a_count_step: assert property ( // [RULE5]
      @(posedge pclk) disable iff (!presetn)
      (tick && !cnt_wr) |=> (cnt_q == $past(cnt_q) + 32'h00000001)
   ) else $error("counter did not advance on tick");

   a_alarm_match: assert property ( // [RULE5]
      @(posedge pclk) disable iff (!presetn)
      hit |=> (sts_q[`RTCB_ST_ALARM] && cnt_q == alarm_q)
   ) else $error("alarm not raised on compare match");

   a_reload_default: assert property ( // [RULE6]
      @(posedge pclk) disable iff (!presetn)
      !reload_wr_seen_q |-> (reload_q == `RTCB_RELOAD_RST)
   ) else $error("prescaler reload lost its default");

   a_lowpow_run: assert property ( // [RULE7]
      @(posedge pclk) disable iff (!presetn)
      (low_power && src_edge_q && !reload_wr && pval != 20'h00000)
      |=> (pval == $past(pval) - 20'h00001)
   ) else $error("prescaler stalled in low power");

   a_wake_alarm: assert property ( // [RULE8]
      @(posedge pclk) disable iff (!presetn)
      (low_power && ctrl_q[`RTCB_CTRL_WKEN] && sts_q[`RTCB_ST_ALARM]) |=> wakeup
   ) else $error("alarm did not raise wake-up");

   a_presc_wrap: assert property ( // [RULE9]
      @(posedge pclk) disable iff (!presetn)
      (src_edge_q && !reload_wr && pval == 20'h00000) |=> (tick && pval == $past(reload_q))
   ) else $error("prescaler wrap wrong");

   a_src_off: assert property ( // [RULE3]
      @(posedge pclk) disable iff (!presetn)
      (src == RTCB_SRC_OFF) |=> !src_edge_q
   ) else $error("stopped source still produced an edge");

   a_alarm_only: assert property ( // [RULE5]
      @(posedge pclk) disable iff (!presetn)
      (!hit && !sts_q[`RTCB_ST_ALARM]) |=> !sts_q[`RTCB_ST_ALARM]
   ) else $error("alarm flag set without compare match");

   a_wake_gate: assert property ( // [RULE8]
      @(posedge pclk) disable iff (!presetn)
      !low_power |=> !wakeup
   ) else $error("wake-up raised outside low power");

endmodule
`default_nettype wire

// file: verif/testbench.sv
`include "rtcb_consts.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import rtcb_pkg::*;
   logic        pclk, presetn, bkp_rstn, psel, penable, pwrite, low_power;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [2:0]  src_clk;
   wire logic [31:0] prdata;
   wire logic        pready, pslverr, irq, wakeup, cal_out;
   int          miscompares, n_checks, cal_toggles;
   logic        cal_prev;

   rtcb_top u_rtcb_top (
      .pclk(pclk), .presetn(presetn), .bkp_rstn(bkp_rstn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .lse_clk(src_clk[0]), .lsi_clk(src_clk[1]), .high_speed_external_clock(src_clk[2]),
      .low_power(low_power), .irq(irq), .wakeup(wakeup), .cal_out(cal_out));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (cal_prev !== cal_out) cal_toggles++;
      cal_prev = cal_out;
   end

   task automatic test_done;
      if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer: setup, then access held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
   endtask

   // n rising edges on one source, h pclk cycles per phase
   task automatic pulse(input int which, input int n, input int h);
      repeat (n) begin
         @(posedge pclk);
         src_clk[which] <= 1'b1;
         repeat (h) @(posedge pclk);
         src_clk[which] <= 1'b0;
         repeat (h - 1) @(posedge pclk);
      end
      repeat (5) @(posedge pclk);
   endtask

   task automatic t_reset;
      rd(`RTCB_OFF_CTRL, 32'h0);
      rd(`RTCB_OFF_STAT, 32'h0);
      rd(`RTCB_OFF_MASK, 32'h0);
      rd(`RTCB_OFF_RELOAD, 32'h0000_7FFF);
      rd(`RTCB_OFF_PVAL, 32'h0000_7FFF);
      rd(`RTCB_OFF_CNT, 32'h0);
      rd(`RTCB_OFF_ALARM, 32'hFFFF_FFFF);
   endtask

   task automatic t_backup;
      logic [31:0] r;
      logic        e;
      for (int i = 0; i < `RTCB_BKP_WORDS; i++) wr(12'(`RTCB_OFF_BKP0 + 4 * i), {16'hFFFF, 16'(16'h1111 * (i + 1))});
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < `RTCB_BKP_WORDS; i++) rd(12'(`RTCB_OFF_BKP0 + 4 * i), {16'h0, 16'(16'h1111 * (i + 1))});
      apb(1'b0, 12'h068, 32'h0, r, e);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, 12'h01C, 32'h5, r, e);
      chk({31'h0, e}, 32'h1);
      @(posedge pclk);
      bkp_rstn <= 1'b0;
      repeat (2) @(posedge pclk);
      bkp_rstn <= 1'b1;
      rd(`RTCB_OFF_BKP0, 32'h0);
      rd(12'(`RTCB_OFF_BKP0 + 36), 32'h0);
   endtask

   task automatic t_chain;
      wr(`RTCB_OFF_RELOAD, 32'h2);
      rd(`RTCB_OFF_PVAL, 32'h2);
      wr(`RTCB_OFF_PVAL, 32'h5);
      rd(`RTCB_OFF_PVAL, 32'h2);
      wr(`RTCB_OFF_CNT, 32'hFFFF_FFFE);
      pulse(0, 5, 3);
      rd(`RTCB_OFF_CNT, 32'hFFFF_FFFF);
      rd(`RTCB_OFF_PVAL, 32'h0);
      pulse(0, 1, 3);
      rd(`RTCB_OFF_CNT, 32'h0);
      rd(`RTCB_OFF_STAT, 32'h3);
      wr(`RTCB_OFF_STAT, 32'h3);
      rd(`RTCB_OFF_STAT, 32'h0);
   endtask

   task automatic t_sources;
      wr(`RTCB_OFF_RELOAD, 32'h0);
      wr(`RTCB_OFF_CTRL, 32'(RTCB_SRC_LSI));
      wr(`RTCB_OFF_CNT, 32'h0);
      pulse(1, 5, 2);
      pulse(0, 3, 2);
      rd(`RTCB_OFF_CNT, 32'h5);
      wr(`RTCB_OFF_CTRL, 32'(RTCB_SRC_FAST));
      wr(`RTCB_OFF_CNT, 32'h0);
      pulse(2, 256, 1);
      rd(`RTCB_OFF_CNT, 32'h2);
      wr(`RTCB_OFF_CTRL, 32'(RTCB_SRC_OFF));
      pulse(0, 2, 2);
      pulse(1, 2, 2);
      pulse(2, 128, 1);
      rd(`RTCB_OFF_CNT, 32'h2);
   endtask

   task automatic t_alarm;
      wr(`RTCB_OFF_CTRL, 32'h8);
      wr(`RTCB_OFF_STAT, 32'h3);
      wr(`RTCB_OFF_ALARM, 32'h7);
      wr(`RTCB_OFF_CNT, 32'h7);
      rd(`RTCB_OFF_STAT, 32'h0);
      wr(`RTCB_OFF_CNT, 32'h5);
      wr(`RTCB_OFF_MASK, 32'h2);
      low_power <= 1'b1;
      pulse(0, 1, 3);
      rd(`RTCB_OFF_STAT, 32'h1);
      chk({wakeup, irq}, 32'h0);
      pulse(0, 1, 3);
      rd(`RTCB_OFF_CNT, 32'h7);
      rd(`RTCB_OFF_STAT, 32'h3);
      chk({wakeup, irq}, 32'h3);
      wr(`RTCB_OFF_STAT, 32'h2);
      repeat (3) @(posedge pclk);
      chk({wakeup, irq}, 32'h0);
      wr(`RTCB_OFF_MASK, 32'h1);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      wr(`RTCB_OFF_STAT, 32'h1);
      low_power <= 1'b0;
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
   endtask

   task automatic t_cal;
      wr(`RTCB_OFF_CTRL, 32'h4);
      pulse(0, 16, 3);
      cal_toggles = 0;
      pulse(0, 256, 3);
      chk(32'(cal_toggles), 32'd8);
      wr(`RTCB_OFF_CTRL, 32'h0);
      repeat (3) @(posedge pclk);
      chk({31'h0, cal_out}, 32'h0);
   endtask

   initial begin
      presetn = 1'b0;
      bkp_rstn = 1'b0;
      {psel, penable, pwrite, low_power} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      src_clk = 3'h0;
      miscompares = 0;
      n_checks = 0;
      cal_toggles = 0;
      cal_prev = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      bkp_rstn <= 1'b1;
      t_reset();
      t_backup();
      t_chain();
      t_sources();
      t_alarm();
      t_cal();
      test_done();
   end

   initial begin
      #400us;
      miscompares++;
      test_done();
   end
endmodule
`default_nettype wire
